//--- mau_pkg.sv
package mau_pkg;
    // register byte addresses
    localparam logic [15:0] ADDR_MULT_A = 16'h1be0;
    localparam logic [15:0] ADDR_MULT_B = 16'h1be4;
    localparam logic [15:0] ADDR_ACC_LO = 16'h1be8;
    localparam logic [15:0] ADDR_ACC_HI = 16'h1bec;
    localparam logic [15:0] ADDR_CTRL = 16'h1bfc;
    // control field positions
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_SIGN_BIT = 2;
    localparam int CTRL_TRIG_LSB = 3;
    localparam int CTRL_START_BIT = 6;
    localparam int CTRL_OVF_BIT = 7;
    // reset values
    localparam logic [31:0] DATA_RESET = 32'h0000_0000;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // timing in system clocks after a start
    localparam int LOW_VALID_CYCLES = 1;
    localparam int HIGH_VALID_CYCLES = 2;

    typedef enum logic [1:0] {
        MAU_MODE_ADD = 2'b00,
        MAU_MODE_SUB_ACC = 2'b01,
        MAU_MODE_SUB_PROD = 2'b10,
        MAU_MODE_RSVD = 2'b11
    } mau_mode_t;

    typedef enum logic [2:0] {
        MAU_TRIG_MULT_A = 3'b000,
        MAU_TRIG_MULT_B = 3'b001,
        MAU_TRIG_ACC_LO = 3'b010,
        MAU_TRIG_ACC_HI = 3'b011,
        MAU_TRIG_SOFT = 3'b100
    } mau_trig_t;
endpackage

//--- mau_arith.sv
`timescale 1ns/1ns
// one-cycle product and 66-bit accumulate with range check
module mau_arith (
    // operands
    input wire logic [31:0] mult_a_i,
    input wire logic [31:0] mult_b_i,
    input wire logic [63:0] acc_i,
    // controls
    input wire logic [1:0] mode_i,
    input wire logic sign_i,
    // result
    output logic [63:0] result_o,
    output logic ovf_o
);
    logic [65:0] prod_x;
    logic [65:0] acc_x;
    logic [65:0] sum_x;

    always_comb begin
        // extend to 66 bits so every result is exact
        if (sign_i) begin
            prod_x = 66'($signed({{2{mult_a_i[31]}}, mult_a_i}) * $signed({{2{mult_b_i[31]}}, mult_b_i}));
            acc_x = {{2{acc_i[63]}}, acc_i};
        end else begin
            prod_x = {2'b00, 64'(mult_a_i * mult_b_i)};
            acc_x = {2'b00, acc_i};
        end
        case (mode_i)
            mau_pkg::MAU_MODE_SUB_ACC: sum_x = acc_x - prod_x;
            mau_pkg::MAU_MODE_SUB_PROD: sum_x = prod_x - acc_x;
            default: sum_x = acc_x + prod_x;
        endcase
        result_o = sum_x[63:0];
        // out of 64-bit range for the active format
        if (sign_i) begin
            ovf_o = (sum_x[65] != sum_x[64]) || (sum_x[64] != sum_x[63]);
        end else begin
            ovf_o = (sum_x[65:64] != 2'b00);
        end
    end
endmodule

//--- mau_top.sv
`timescale 1ns/1ns
module mau_top (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // register bus
    input wire logic [15:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic [3:0] be_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    output logic ack_o
);
    logic [31:0] mult_a_ff, nxt_mult_a;
    logic [31:0] mult_b_ff, nxt_mult_b;
    logic [31:0] acc_lo_ff, nxt_acc_lo;
    logic [31:0] acc_hi_ff, nxt_acc_hi;
    logic [1:0] mode_ff, nxt_mode;
    logic sign_ff, nxt_sign;
    logic [2:0] trig_ff, nxt_trig;
    logic ovf_ff, nxt_ovf;
    logic start_ff, nxt_start;
    logic hi_pend_ff, nxt_hi_pend;
    logic [31:0] hi_res_ff, nxt_hi_res;
    logic ovf_res_ff, nxt_ovf_res;
    logic [31:0] rdata_ff, nxt_rdata;
    logic ack_ff, nxt_ack;
    logic [63:0] arith_res;
    logic arith_ovf;
    logic start_now;
    logic [31:0] acc_hi_fwd;

    function automatic logic [31:0] merge_be(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // back-to-back starts see the high word still in flight
    assign acc_hi_fwd = hi_pend_ff ? hi_res_ff : acc_hi_ff;

    mau_arith u_arith (
        .mult_a_i(mult_a_ff),
        .mult_b_i(mult_b_ff),
        .acc_i({acc_hi_fwd, acc_lo_ff}),
        .mode_i(mode_ff),
        .sign_i(sign_ff),
        .result_o(arith_res),
        .ovf_o(arith_ovf)
    );

    // decide whether this write starts a calculation
    always_comb begin
        logic [2:0] trig_sel;
        trig_sel = trig_ff;
        start_now = 1'b0;
        if (wr_i && addr_i == mau_pkg::ADDR_CTRL && be_i[0]) begin
            trig_sel = wdata_i[mau_pkg::CTRL_TRIG_LSB +: 3];
            start_now = trig_sel[2] && wdata_i[mau_pkg::CTRL_START_BIT];
        end else if (wr_i && be_i[0] && !trig_sel[2]) begin
            if (addr_i == mau_pkg::ADDR_MULT_A) begin
                start_now = (trig_sel == mau_pkg::MAU_TRIG_MULT_A);
            end else if (addr_i == mau_pkg::ADDR_MULT_B) begin
                start_now = (trig_sel == mau_pkg::MAU_TRIG_MULT_B);
            end else if (addr_i == mau_pkg::ADDR_ACC_LO) begin
                start_now = (trig_sel == mau_pkg::MAU_TRIG_ACC_LO);
            end else if (addr_i == mau_pkg::ADDR_ACC_HI) begin
                start_now = (trig_sel == mau_pkg::MAU_TRIG_ACC_HI);
            end
        end
    end

    always_comb begin
        nxt_mult_a = mult_a_ff;
        nxt_mult_b = mult_b_ff;
        nxt_acc_lo = acc_lo_ff;
        nxt_acc_hi = acc_hi_ff;
        nxt_mode = mode_ff;
        nxt_sign = sign_ff;
        nxt_trig = trig_ff;
        nxt_ovf = ovf_ff;
        nxt_start = start_now;
        nxt_hi_pend = 1'b0;
        nxt_hi_res = hi_res_ff;
        nxt_ovf_res = ovf_res_ff;
        // register writes; operands land before the start clock
        if (wr_i) begin
            if (addr_i == mau_pkg::ADDR_MULT_A) begin
                nxt_mult_a = merge_be(mult_a_ff, wdata_i, be_i);
            end else if (addr_i == mau_pkg::ADDR_MULT_B) begin
                nxt_mult_b = merge_be(mult_b_ff, wdata_i, be_i);
            end else if (addr_i == mau_pkg::ADDR_ACC_LO) begin
                nxt_acc_lo = merge_be(acc_lo_ff, wdata_i, be_i);
            end else if (addr_i == mau_pkg::ADDR_ACC_HI) begin
                nxt_acc_hi = merge_be(acc_hi_ff, wdata_i, be_i);
            end else if (addr_i == mau_pkg::ADDR_CTRL && be_i[0]) begin
                nxt_mode = wdata_i[mau_pkg::CTRL_MODE_LSB +: 2];
                nxt_sign = wdata_i[mau_pkg::CTRL_SIGN_BIT];
                nxt_trig = wdata_i[mau_pkg::CTRL_TRIG_LSB +: 3];
                if (!wdata_i[mau_pkg::CTRL_OVF_BIT]) begin
                    nxt_ovf = 1'b0;
                end
            end
        end
        // stage 1: compute, low word lands one clock after start
        if (start_ff) begin
            nxt_acc_lo = arith_res[31:0];
            nxt_hi_res = arith_res[63:32];
            nxt_ovf_res = arith_ovf;
            nxt_hi_pend = 1'b1;
        end
        // stage 2: high word and flag two clocks after start
        if (hi_pend_ff) begin
            nxt_acc_hi = hi_res_ff;
            if (ovf_res_ff) begin
                nxt_ovf = 1'b1;
            end
        end
    end

    // read path, answered the clock after the request
    always_comb begin
        nxt_ack = wr_i || rd_i;
        nxt_rdata = 32'h0000_0000;
        if (rd_i) begin
            if (addr_i == mau_pkg::ADDR_MULT_A) begin
                nxt_rdata = mult_a_ff;
            end else if (addr_i == mau_pkg::ADDR_MULT_B) begin
                nxt_rdata = mult_b_ff;
            end else if (addr_i == mau_pkg::ADDR_ACC_LO) begin
                nxt_rdata = acc_lo_ff;
            end else if (addr_i == mau_pkg::ADDR_ACC_HI) begin
                nxt_rdata = acc_hi_ff;
            end else if (addr_i == mau_pkg::ADDR_CTRL) begin
                nxt_rdata = {24'h00_0000, ovf_ff, 1'b0, trig_ff, sign_ff, mode_ff};
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            mult_a_ff <= mau_pkg::DATA_RESET;
            mult_b_ff <= mau_pkg::DATA_RESET;
            acc_lo_ff <= mau_pkg::DATA_RESET;
            acc_hi_ff <= mau_pkg::DATA_RESET;
            mode_ff <= mau_pkg::CTRL_RESET[1:0];
            sign_ff <= 1'b0;
            trig_ff <= mau_pkg::CTRL_RESET[5:3];
            ovf_ff <= 1'b0;
            start_ff <= 1'b0;
            hi_pend_ff <= 1'b0;
            hi_res_ff <= mau_pkg::DATA_RESET;
            ovf_res_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            ack_ff <= 1'b0;
        end else begin
            mult_a_ff <= nxt_mult_a;
            mult_b_ff <= nxt_mult_b;
            acc_lo_ff <= nxt_acc_lo;
            acc_hi_ff <= nxt_acc_hi;
            mode_ff <= nxt_mode;
            sign_ff <= nxt_sign;
            trig_ff <= nxt_trig;
            ovf_ff <= nxt_ovf;
            start_ff <= nxt_start;
            hi_pend_ff <= nxt_hi_pend;
            hi_res_ff <= nxt_hi_res;
            ovf_res_ff <= nxt_ovf_res;
            rdata_ff <= nxt_rdata;
            ack_ff <= nxt_ack;
        end
    end

    assign rdata_o = rdata_ff;
    assign ack_o = ack_ff;

    sequence s_start;
        start_now;
    endsequence

    sequence s_low_ready;
        ##2 hi_pend_ff;
    endsequence

    a_low_result_time: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        start_ff |=> acc_lo_ff == $past(arith_res[31:0]))
        else $error("low word not loaded one clock after start");

    a_high_result_time: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        start_ff ##1 1'b1 |=> acc_hi_ff == $past(hi_res_ff))
        else $error("high word not loaded two clocks after start");

    a_start_pipeline: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        s_start |-> s_low_ready)
        else $error("calculation pipeline did not advance");

    a_ovf_sticky: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        ovf_ff && !(wr_i && addr_i == mau_pkg::ADDR_CTRL && be_i[0]) |=> ovf_ff)
        else $error("overflow flag dropped without a write");

    a_ovf_set: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        hi_pend_ff && ovf_res_ff |=> ovf_ff)
        else $error("overflow not flagged");

    a_soft_start: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        wr_i && addr_i == mau_pkg::ADDR_CTRL && be_i[0] && wdata_i[6] && wdata_i[5] |=> start_ff)
        else $error("soft start ignored");

    a_start_reads_zero: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        rd_i && addr_i == mau_pkg::ADDR_CTRL |=> rdata_o[6] == 1'b0)
        else $error("soft start bit read back nonzero");

    a_ctrl_keeps_data: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        wr_i && addr_i == mau_pkg::ADDR_CTRL && !start_ff && !hi_pend_ff |=> $stable(acc_lo_ff) && $stable(mult_a_ff))
        else $error("control write changed data registers");

    a_one_clock_ack: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (wr_i || rd_i) |=> ack_o)
        else $error("access not answered in one clock");

    sequence s_lane0_write;
        wr_i && be_i[0];
    endsequence

    a_reset_clears: assert property (@(posedge clk_sys_i)
        !resetn_i |=> mult_a_ff == mau_pkg::DATA_RESET && mult_b_ff == mau_pkg::DATA_RESET
            && acc_lo_ff == mau_pkg::DATA_RESET && acc_hi_ff == mau_pkg::DATA_RESET && !ovf_ff)
        else $error("data registers not cleared by reset");

    a_reset_quiet: assert property (@(posedge clk_sys_i)
        !resetn_i |=> !ack_o && rdata_o == 32'h0000_0000 && mode_ff == 2'b00 && trig_ff == 3'b000 && !sign_ff)
        else $error("bus outputs or control fields not quiet in reset");

    a_no_ack_idle: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        !(wr_i || rd_i) |=> !ack_o)
        else $error("acknowledge without an access");

    a_rdata_idle: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        !rd_i |=> rdata_o == 32'h0000_0000)
        else $error("read data not zero outside a read");

    a_trig_mult_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        s_lane0_write ##0 (addr_i == mau_pkg::ADDR_MULT_A && trig_ff == mau_pkg::MAU_TRIG_MULT_A) |=> start_ff)
        else $error("multiplier a write did not start");

    a_trig_mult_b: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        s_lane0_write ##0 (addr_i == mau_pkg::ADDR_MULT_B && trig_ff == mau_pkg::MAU_TRIG_MULT_B) |=> start_ff)
        else $error("multiplier b write did not start");

    a_trig_acc_lo: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        s_lane0_write ##0 (addr_i == mau_pkg::ADDR_ACC_LO && trig_ff == mau_pkg::MAU_TRIG_ACC_LO) |=> start_ff)
        else $error("accumulator low write did not start");

    a_trig_acc_hi: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        s_lane0_write ##0 (addr_i == mau_pkg::ADDR_ACC_HI && trig_ff == mau_pkg::MAU_TRIG_ACC_HI) |=> start_ff)
        else $error("accumulator high write did not start");

    a_upper_lane_quiet: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        wr_i && !be_i[0] |=> !start_ff)
        else $error("start fired without bits 7:0 written");

    a_soft_zero_idle: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        s_lane0_write ##0 (addr_i == mau_pkg::ADDR_CTRL && !wdata_i[mau_pkg::CTRL_START_BIT]) |=> !start_ff)
        else $error("writing zero to soft start began a calculation");

    a_ovf_clear: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        s_lane0_write ##0 (addr_i == mau_pkg::ADDR_CTRL && !wdata_i[mau_pkg::CTRL_OVF_BIT]
            && !(hi_pend_ff && ovf_res_ff)) |=> !ovf_ff)
        else $error("overflow flag not cleared by a zero write");

    a_ctrl_fields: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        s_lane0_write ##0 (addr_i == mau_pkg::ADDR_CTRL) |=> mode_ff == $past(wdata_i[mau_pkg::CTRL_MODE_LSB +: 2])
            && sign_ff == $past(wdata_i[mau_pkg::CTRL_SIGN_BIT]) && trig_ff == $past(wdata_i[mau_pkg::CTRL_TRIG_LSB +: 3]))
        else $error("control fields not taken from the write");

    a_mult_a_write: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        wr_i && addr_i == mau_pkg::ADDR_MULT_A && be_i == 4'hf |=> mult_a_ff == $past(wdata_i))
        else $error("multiplier a word write lost");

    a_acc_hi_write: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        wr_i && addr_i == mau_pkg::ADDR_ACC_HI && be_i == 4'hf && !hi_pend_ff |=> acc_hi_ff == $past(wdata_i))
        else $error("accumulator high word write lost");
endmodule

//--- mau_host.sv
`timescale 1ns/1ns
// host side of the register bus, one access at a time
module mau_host (
    // clock
    input wire logic clk_sys_i,
    // register bus
    output logic [15:0] addr_o,
    output logic [31:0] wdata_o,
    output logic [3:0] be_o,
    output logic wr_o,
    output logic rd_o,
    input wire logic [31:0] rdata_i,
    input wire logic ack_i
);
    logic [31:0] seen;
    logic got_ack;

    initial begin
        addr_o = 16'h0000;
        wdata_o = 32'h0000_0000;
        be_o = 4'h0;
        wr_o = 1'h0;
        rd_o = 1'h0;
        seen = 32'h0000_0000;
        got_ack = 1'h0;
    end

    // one strobe cycle, answer taken at the edge that samples ack; control only written whole
    task automatic access(input logic wr, input logic [15:0] addr, input logic [31:0] data, input logic [3:0] be);
        int n;
        @(posedge clk_sys_i);
        addr_o <= addr;
        wdata_o <= data;
        be_o <= be;
        wr_o <= wr;
        rd_o <= !wr;
        @(posedge clk_sys_i);
        wr_o <= 1'h0;
        rd_o <= 1'h0;
        n = 0;
        got_ack = 1'h0;
        while (!got_ack && n < 4) begin
            @(posedge clk_sys_i);
            got_ack = (ack_i === 1'h1);
            n++;
        end
        seen = rdata_i;
        addr_o <= ~addr;
        wdata_o <= ~data;
    endtask
endmodule

//--- test_multiply_accumulate_unit.sv
`timescale 1ns/1ns
module test_multiply_accumulate_unit;
    logic clk_sys_i;
    logic resetn_i = 1'h0;
    logic [15:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [3:0] be;
    logic wr;
    logic rd;
    logic ack;
    logic exp_ovf = 1'h0;
    int failures = 0;
    int checked = 0;
    int cycles = 0;

    mau_top u_dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .addr_i(addr), .wdata_i(wdata), .be_i(be),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .ack_o(ack));

    mau_host u_host (.clk_sys_i(clk_sys_i), .addr_o(addr), .wdata_o(wdata), .be_o(be), .wr_o(wr), .rd_o(rd),
        .rdata_i(rdata), .ack_i(ack));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [15:0] a, input logic [31:0] d, input logic [3:0] b);
        u_host.access(1'h1, a, d, b);
        chk({31'h0, u_host.got_ack}, 32'h0000_0001);
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
        u_host.access(1'h0, a, 32'h0000_0000, 4'hf);
        chk({31'h0, u_host.got_ack}, 32'h0000_0001);
        chk(u_host.seen, exp);
    endtask

    task automatic test_done();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // reset values, unmapped place, byte lanes
    task automatic test_reset();
        for (int i = 0; i < 4; i++) begin
            rd_chk(mau_pkg::ADDR_MULT_A + 16'(4 * i), mau_pkg::DATA_RESET);
        end
        rd_chk(mau_pkg::ADDR_CTRL, {24'h00_0000, mau_pkg::CTRL_RESET});
        rd_chk(16'h1bf0, 32'h0000_0000);
        wr_reg(mau_pkg::ADDR_MULT_B, 32'h1122_3344, 4'hf);
        wr_reg(mau_pkg::ADDR_MULT_B, 32'haabb_ccdd, 4'h4);
        rd_chk(mau_pkg::ADDR_MULT_B, 32'h11bb_3344);
        wr_reg(mau_pkg::ADDR_MULT_A, 32'h0000_0500, 4'h2);
        rd_chk(mau_pkg::ADDR_ACC_LO, 32'h0000_0000);
        $display("test_reset done");
    endtask

    // load operands under soft trigger, arm the chosen trigger, start, read low then high
    task automatic test_calc(input logic [1:0] mode, input logic sign, input logic [2:0] trig,
        input logic [63:0] acc, input logic [31:0] a, input logic [31:0] b, input logic clr);
        logic [65:0] p;
        logic [65:0] x;
        logic [65:0] r;
        logic ov;
        logic keep;
        logic [15:0] ta;
        logic [31:0] td;
        p = sign ? {{34{a[31]}}, a} * {{34{b[31]}}, b} : {34'h0, a} * {34'h0, b};
        x = sign ? {{2{acc[63]}}, acc} : {2'h0, acc};
        r = (mode == 2'h1) ? x - p : (mode == 2'h2) ? p - x : x + p;
        ov = sign ? (r[65:63] != 3'h0 && r[65:63] != 3'h7) : (r[65:64] != 2'h0);
        keep = exp_ovf & !clr;
        exp_ovf = keep | ov;
        ta = (trig == 3'h0) ? mau_pkg::ADDR_MULT_A : (trig == 3'h1) ? mau_pkg::ADDR_MULT_B :
            (trig == 3'h2) ? mau_pkg::ADDR_ACC_LO : mau_pkg::ADDR_ACC_HI;
        td = (trig == 3'h0) ? a : (trig == 3'h1) ? b : (trig == 3'h2) ? acc[31:0] : acc[63:32];
        wr_reg(mau_pkg::ADDR_CTRL, {24'h0, keep, 1'h0, 3'h4, sign, mode}, 4'hf);
        wr_reg(mau_pkg::ADDR_ACC_HI, acc[63:32], 4'hf);
        wr_reg(mau_pkg::ADDR_ACC_LO, acc[31:0], 4'hf);
        wr_reg(mau_pkg::ADDR_MULT_A, a, 4'hf);
        wr_reg(mau_pkg::ADDR_MULT_B, b, 4'hf);
        wr_reg(mau_pkg::ADDR_CTRL, {24'h0, keep, trig[2], trig, sign, mode}, 4'hf);
        if (!trig[2]) begin
            wr_reg(ta, td, 4'hf);
        end
        @(posedge clk_sys_i);
        rd_chk(mau_pkg::ADDR_ACC_LO, r[31:0]);
        rd_chk(mau_pkg::ADDR_ACC_HI, r[63:32]);
        rd_chk(mau_pkg::ADDR_CTRL, {24'h0, exp_ovf, 1'h0, trig, sign, mode});
        $display("test_calc mode %h sign %h trig %h done", mode, sign, trig);
    endtask

    initial begin
        clk_sys_i = 1'h0;
        forever #25 clk_sys_i = ~clk_sys_i;
    end

    always @(posedge clk_sys_i) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            failures++;
            test_done();
        end
    end

    initial begin
        repeat (5) @(posedge clk_sys_i);
        resetn_i <= 1'h1;
        test_reset();
        test_calc(2'h0, 1'h0, 3'h1, 64'h3333_3333, 32'h1111_1111, 32'h2222_2222, 1'h0);
        test_calc(2'h1, 1'h1, 3'h4, 64'h3333_3333, 32'h1111_1111, 32'hdddd_ddde, 1'h0);
        test_calc(2'h2, 1'h0, 3'h0, 64'h1, 32'h2, 32'h3, 1'h0);
        test_calc(2'h1, 1'h0, 3'h2, 64'h0, 32'h1, 32'h1, 1'h0);
        test_calc(2'h0, 1'h0, 3'h3, 64'h5, 32'h2, 32'h2, 1'h0);
        test_calc(2'h0, 1'h1, 3'h7, 64'h7fff_ffff_ffff_ffff, 32'h1, 32'h1, 1'h1);
        test_calc(2'h0, 1'h0, 3'h5, 64'hffff_ffff_ffff_fffb, 32'h2, 32'h3, 1'h1);
        test_calc(2'h2, 1'h1, 3'h1, 64'h0, 32'h8000_0000, 32'h8000_0000, 1'h1);
        test_calc(2'h3, 1'h0, 3'h6, 64'h10, 32'h3, 32'h4, 1'h0);
        test_done();
    end
endmodule
